/* include/inband_reset_pkg.sv */
/*
  shared constants and carrier types for the in-band reset and error-clear block.
  assumes a single 25 MHz system clock and an asynchronous active-high reset.
*/
package inband_reset_pkg;
  // ==========================================================
  // opcodes and field widths
  localparam logic [7:0] error_clear_opcode = 8'hb6;
  localparam logic [3:0] reset_pattern = 4'h5; // msb is the first pulse
  localparam int pulse_count = 4;
  localparam int ecc_status_width = 3;
  localparam int ecc_counter_width = 4;
  localparam int chunk_addr_width = 32;

  // ==========================================================
  // default values of volatile error fields
  localparam logic [2:0] ecc_status_reset = 3'h0;
  localparam logic [3:0] ecc_counter_reset = 4'h0;
  localparam logic [31:0] chunk_addr_reset = 32'h0;

  // ==========================================================
  // timing
  localparam int clk_period_ns = 40;
  localparam int select_low_time_ns = 500;
  localparam int select_high_time_ns = 500;
  localparam int reset_busy_ns = 1000;
  localparam int reset_busy_cycles = (reset_busy_ns + clk_period_ns - 1) / clk_period_ns;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_reset = 2'b01
  } detect_e;

  // volatile error status carried as one group
  typedef struct packed {
    logic [2:0] ecc_status_field;
    logic address_parity_status;
    logic data_check_status;
    logic [3:0] ecc_event_counter;
    logic illegal_program_flag;
    logic [31:0] first_event_chunk_address;
  } err_status_s;

  // events raised by the rest of the device
  typedef struct packed {
    logic ecc_event;
    logic [2:0] ecc_status;
    logic [31:0] chunk_address;
    logic parity_error;
    logic crc_error;
    logic illegal_program;
  } err_event_s;
endpackage

/* verilog/inband_reset_error_clear.sv */
/*
  in-band reset detector and error-clear logic of a serial flash device.
  assumes chip select, data line zero and serial clock are asynchronous pins,
  and that command decode delivers a one-cycle opcode strobe on mclk.
  assumes the host keeps each select phase well above three mclk periods;
  shorter pulses may be lost in the synchronisers.
  chip select and data line zero pass identical two-flop paths, so the level
  seen at a select rise is the level that stood on the pin at that rise.
  a select rise is acted on three mclk after the pin moves.
  error events from the rest of the device arrive as one-cycle pulses on mclk;
  soft and hard reset requests arrive on mclk as well.
  the busy window after an in-band reset lasts busy_cycles mclk periods;
  error events still land during it, opcode clears do not.
  data line zero is never driven while the busy window runs.
  error_n_out is the open-drain level and error_n_oe pulls it low when low.
*/
// Contract
// [RQ1] clear-error opcode releases error output
// [RQ2] clear-error opcode defaults all volatile error fields
// [RQ3] power-on, hardware, software reset clear errors
// [RQ4] in-band reset uses chip select, data zero
// [RQ5] host holds serial clock steady throughout
// [RQ6] host drives data zero low-high-low-high
// [RQ7] sample data zero at chip select rise
// [RQ8] fourth matching pulse triggers internal reset
// [RQ9] no data zero drive before first clock
// [RQ10] detector works in any device state
// [RQ11] ignore chip select during reset
// [RQ12] resume normal operation after reset completes
// [RQ13] host holds each select phase 500 ns
// [RQ14] host uses it only for recovery
// [RQ15] error output low from event until cleared
// [RQ16] in-band reset also clears error fields
// [RQ17] pattern break restarts pulse count
module inband_reset_error_clear
  import inband_reset_pkg::*;
#(
  parameter int busy_cycles = reset_busy_cycles
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic select_n_pin,
  input wire logic data_line_zero_in,
  input wire logic serial_clk_pin,
  input wire logic dq0_out_req,
  input wire logic opcode_valid,
  input wire logic [7:0] opcode,
  input wire logic soft_reset,
  input wire logic hard_reset,
  input wire err_event_s err_event,
  output logic error_n_out,
  output logic error_n_oe,
  output logic data_line_zero_oe,
  output logic inband_reset_pulse,
  output logic device_busy,
  output err_status_s err_status
);

  // ==========================================================
  // state
  // state: one packed record, registered in a single process
  typedef struct packed {
    logic [1:0] cs_sync;
    logic [1:0] d0_sync;
    logic [1:0] sck_sync;
    logic cs_prev;
    logic sck_prev;
    logic first_edge_seen;
    logic [2:0] pulse_idx;
    logic [15:0] busy_cnt;
    detect_e mode;
    logic error_active;
    logic reset_pulse;
    err_status_s stat;
  } state_s;

  state_s state_q;
  state_s state_d;

  logic cs_rise;
  logic clear_all;
  logic expected_bit;

  // pattern bit expected on a given pulse; the first pulse is the msb
  // of the pattern, so pulses carry low, high, low, high in turn
  function automatic logic pattern_bit(input logic [2:0] idx);
    pattern_bit = reset_pattern[2'(pulse_count - 1) - idx[1:0]];
  endfunction

  // ==========================================================
  // next state
  // the whole block is one state record; synchroniser shifts, edge
  // detection, pulse counting, busy window and error fields all settle here
  always_comb begin
    state_d = state_q;
    state_d.reset_pulse = 1'b0;
    // two-flop synchronisers on the pins
    // only the second flop of each pair is read by logic
    state_d.cs_sync = {state_q.cs_sync[0], select_n_pin};
    state_d.d0_sync = {state_q.d0_sync[0], data_line_zero_in};
    state_d.sck_sync = {state_q.sck_sync[0], serial_clk_pin};
    state_d.cs_prev = state_q.cs_sync[1];
    state_d.sck_prev = state_q.sck_sync[1];
    cs_rise = state_q.cs_sync[1] & ~state_q.cs_prev;
    expected_bit = pattern_bit(state_q.pulse_idx);
    clear_all = 1'b0;

    // first serial clock edge within a select frame
    // marks the point after which the device may drive data line zero
    if (state_q.cs_sync[1]) begin
      state_d.first_edge_seen = 1'b0;
    end else if (state_q.sck_sync[1] != state_q.sck_prev) begin
      state_d.first_edge_seen = 1'b1;
    end

    // pulse counter: an unclocked select pulse with the expected level
    // advances it, a clocked frame or a wrong level restarts it
    unique case (state_q.mode)
      st_idle: begin
        // detector runs regardless of protocol mode
        if (cs_rise) begin // RQ4 RQ10
          if (state_q.first_edge_seen) begin
            state_d.pulse_idx = 3'h0; // clocked frame is a command
          end else if (state_q.d0_sync[1] == expected_bit) begin // RQ7
            if (state_q.pulse_idx == 3'(pulse_count - 1)) begin
              state_d.pulse_idx = 3'h0;
              state_d.mode = st_reset; // RQ8
              state_d.busy_cnt = 16'(busy_cycles);
              state_d.reset_pulse = 1'b1;
              clear_all = 1'b1; // RQ16
            end else begin
              state_d.pulse_idx = state_q.pulse_idx + 3'h1;
            end
          end else begin
            // a low sample can still start a fresh pattern
            state_d.pulse_idx = state_q.d0_sync[1] ? 3'h0 : 3'h1; // RQ17
          end
        end
      end
      st_reset: begin
        // chip select activity ignored while busy
        if (state_q.busy_cnt <= 16'h1) begin // RQ11
          state_d.mode = st_idle; // RQ12
          state_d.busy_cnt = 16'h0;
        end else begin
          state_d.busy_cnt = state_q.busy_cnt - 16'h1;
        end
      end
      default: state_d.mode = st_idle;
    endcase

    // opcode and other resets clear errors; the opcode is refused while
    // busy, the soft and hard requests are not
    if (state_q.mode == st_idle && opcode_valid && opcode == error_clear_opcode) begin
      clear_all = 1'b1; // RQ1 RQ2
    end
    if (soft_reset || hard_reset) begin
      clear_all = 1'b1; // RQ3
    end

    if (clear_all) begin
      state_d.error_active = 1'b0;
      state_d.stat.ecc_status_field = ecc_status_reset;
      state_d.stat.address_parity_status = 1'b0;
      state_d.stat.data_check_status = 1'b0;
      state_d.stat.ecc_event_counter = ecc_counter_reset;
      state_d.stat.illegal_program_flag = 1'b0;
      state_d.stat.first_event_chunk_address = chunk_addr_reset;
    end

    // new events win over a clear in the same cycle, so an error that
    // lands with the clear is never lost; the counter saturates at 15
    if (err_event.ecc_event) begin
      state_d.error_active = 1'b1; // RQ15
      state_d.stat.ecc_status_field = err_event.ecc_status;
      if (state_q.stat.ecc_event_counter != 4'hf || clear_all) begin
        state_d.stat.ecc_event_counter = clear_all ? 4'h1 :
          state_q.stat.ecc_event_counter + 4'h1;
      end
      if (state_q.stat.ecc_event_counter == 4'h0 || clear_all) begin
        state_d.stat.first_event_chunk_address = err_event.chunk_address;
      end
    end
    if (err_event.parity_error) begin
      state_d.stat.address_parity_status = 1'b1;
    end
    if (err_event.crc_error) begin
      state_d.stat.data_check_status = 1'b1;
    end
    if (err_event.illegal_program) begin
      state_d.stat.illegal_program_flag = 1'b1;
    end
  end

  // ==========================================================
  // registers; async reset is the power-on clear
  // the select synchroniser resets to the idle high level so that
  // no false select rise follows reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= '{cs_sync: 2'h3, d0_sync: 2'h0, sck_sync: 2'h0, cs_prev: 1'b1,
                   sck_prev: 1'b0, first_edge_seen: 1'b0, pulse_idx: 3'h0,
                   busy_cnt: 16'h0, mode: st_idle, error_active: 1'b0,
                   reset_pulse: 1'b0, stat: '0}; // RQ3
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // outputs
  // error_n_oe comes straight from a register and error_n_out is tied low; the data line
  // enable is combinational and releases once the synchronised select reads high, two mclk after the pin rises
  assign error_n_out = 1'b0;
  assign error_n_oe = ~state_q.error_active; // RQ15
  // data zero only driven after first clock edge in a frame
  assign data_line_zero_oe = ~(dq0_out_req & state_q.first_edge_seen
                               & ~state_q.cs_sync[1] & (state_q.mode == st_idle)); // RQ9
  assign inband_reset_pulse = state_q.reset_pulse;
  assign device_busy = (state_q.mode == st_reset);
  assign err_status = state_q.stat;

endmodule

/* sim/inband_reset_assertions.sv */
/* checker for the in-band reset and error-clear block.
   assumes it is bound to the top module and sees its ports only. */
module inband_reset_checker
  import inband_reset_pkg::*;
#(parameter int busy_cycles = reset_busy_cycles) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic select_n_pin,
  input wire logic opcode_valid,
  input wire logic [7:0] opcode,
  input wire logic soft_reset,
  input wire logic hard_reset,
  input wire err_event_s err_event,
  input wire logic error_n_oe,
  input wire logic data_line_zero_oe,
  input wire logic inband_reset_pulse,
  input wire logic device_busy,
  input wire err_status_s err_status
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ==========================================================
  // busy window length, counted in helper logic
  int busy_run;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_run <= 0;
    end else if (device_busy) begin
      busy_run <= busy_run + 1;
    end else begin
      busy_run <= 0;
    end
  end
  // ==========================================================
  // clear requests with no competing event
  sequence clr_s;
    opcode_valid && opcode == error_clear_opcode && !device_busy && err_event == '0;
  endsequence
  sequence rst_s;
    (soft_reset || hard_reset) && err_event == '0;
  endsequence
  chk_clear_release: assert property (clr_s |=> error_n_oe)
    else $error("clear left error line low");
  chk_clear_fields: assert property (clr_s |=> err_status == '0)
    else $error("clear left error fields set");
  chk_reset_clear: assert property (rst_s |=> error_n_oe && err_status == '0)
    else $error("reset did not clear errors");
  chk_event_drive: assert property (err_event.ecc_event |=> !error_n_oe)
    else $error("event did not pull error line");
  chk_error_sticky: assert property (!error_n_oe && !opcode_valid && !soft_reset
    && !hard_reset |=> !error_n_oe || inband_reset_pulse) else $error("error line let go");
  chk_busy_ignore: assert property (device_busy && !error_n_oe && !soft_reset
    && !hard_reset |=> !error_n_oe) else $error("busy window accepted a clear");
  chk_inband_clear: assert property (inband_reset_pulse && $past(err_event) == '0
    |-> error_n_oe && err_status == '0) else $error("in-band reset kept errors");
  chk_pulse_busy: assert property (inband_reset_pulse |-> device_busy ##1 !inband_reset_pulse)
    else $error("reset pulse shape wrong");
  chk_busy_start: assert property ($rose(device_busy) |-> inband_reset_pulse)
    else $error("busy without reset pulse");
  chk_busy_length: assert property ($fell(device_busy) |-> busy_run == busy_cycles)
    else $error("busy window length wrong");
  chk_no_early_drive: assert property (select_n_pin [*3] |-> data_line_zero_oe)
    else $error("data line driven while deselected");
endmodule

bind inband_reset_error_clear inband_reset_checker #(.busy_cycles(busy_cycles)) u_chk (
  .mclk(mclk), .rst(rst), .select_n_pin(select_n_pin), .opcode_valid(opcode_valid),
  .opcode(opcode), .soft_reset(soft_reset), .hard_reset(hard_reset), .err_event(err_event),
  .error_n_oe(error_n_oe), .data_line_zero_oe(data_line_zero_oe),
  .inband_reset_pulse(inband_reset_pulse), .device_busy(device_busy), .err_status(err_status));

/* sim/host_model.sv */
/* host model driving chip select, data line zero and serial clock.
   assumes one bench process calls its frame task at a time. */
module host_model (
  input wire logic mclk,
  output logic select_n_pin,
  output logic data_line_zero_in,
  output logic serial_clk_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    select_n_pin = 1'b1;
    data_line_zero_in = 1'b1;
    serial_clk_pin = 1'b0;
  end
  // one select pulse, 640 ns low and 640 ns high; sck 320 ns period if clocked
  task automatic frame(input logic b, input logic clocked);
    @(posedge mclk);
    select_n_pin <= 1'b0;
    data_line_zero_in <= b;
    for (int i = 1; i <= 16; i++) begin
      @(posedge mclk);
      if (clocked && i % 4 == 0) serial_clk_pin <= ~serial_clk_pin;
    end
    select_n_pin <= 1'b1;
    repeat (4) @(posedge mclk); // hold data past the rise
    data_line_zero_in <= ~b; // released line shows the inverse
    repeat (12) @(posedge mclk);
  endtask
endmodule

/* sim/inband_reset_error_clear_tb.sv */
/* self-checking bench for the in-band reset and error-clear block.
   assumes the host model and the bound checker are compiled with it. */
module inband_reset_error_clear_tb import inband_reset_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic select_n_pin, data_line_zero_in, serial_clk_pin;
  logic opcode_valid = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic soft_reset = 1'b0;
  logic hard_reset = 1'b0;
  err_event_s err_event = '0;
  logic dq0_out_req = 1'b1;
  logic error_n_out, error_n_oe, data_line_zero_oe, inband_reset_pulse, device_busy;
  err_status_s err_status;
  int n_fail = 0;
  int total_checks = 0;
  int oe_low = 0;
  int pulses = 0;
  int p;
  int q;
  initial forever #20 mclk = ~mclk;
  host_model u_host_model (.mclk(mclk), .select_n_pin(select_n_pin),
    .data_line_zero_in(data_line_zero_in), .serial_clk_pin(serial_clk_pin));
  inband_reset_error_clear #(.busy_cycles(reset_busy_cycles)) u_inband_reset_error_clear (
    .mclk(mclk), .rst(rst),
    .select_n_pin(select_n_pin), .data_line_zero_in(data_line_zero_in),
    .serial_clk_pin(serial_clk_pin), .dq0_out_req(dq0_out_req), .opcode_valid(opcode_valid),
    .opcode(opcode), .soft_reset(soft_reset), .hard_reset(hard_reset), .err_event(err_event),
    .error_n_out(error_n_out), .error_n_oe(error_n_oe), .data_line_zero_oe(data_line_zero_oe),
    .inband_reset_pulse(inband_reset_pulse), .device_busy(device_busy), .err_status(err_status));
  // count data line drive cycles and reset pulses
  always @(posedge mclk) begin
    if (!rst && data_line_zero_oe !== 1'b1) oe_low++;
    if (inband_reset_pulse === 1'b1) pulses++;
  end
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one ecc event with all side flags, taken from a cleared state
  task automatic ecc_hit;
    @(posedge mclk);
    err_event <= {1'b1, 3'h2, 32'h40, 3'h7};
    @(posedge mclk);
    err_event <= '0;
    #1;
    check(error_n_oe === 1'b0 && error_n_out === 1'b0, "error line not pulled");
    check(err_status.ecc_event_counter === 4'h1, "event not counted");
    check(err_status.first_event_chunk_address === 32'h40
          && err_status.illegal_program_flag === 1'b1, "event fields not set");
  endtask
  task automatic op(input logic [7:0] code);
    @(posedge mclk);
    opcode_valid <= 1'b1;
    opcode <= code;
    @(posedge mclk);
    opcode_valid <= 1'b0;
    #1;
  endtask
  task automatic test_clear;
    ecc_hit();
    op(8'hb7);
    check(error_n_oe === 1'b0, "other opcode cleared");
    op(error_clear_opcode);
    check(error_n_oe === 1'b1 && err_status === '0, "clear opcode");
    $display("test clear done");
  endtask
  task automatic test_resets;
    // soft, hard, then a power-on reset in mid-run
    for (int i = 0; i < 3; i++) begin
      ecc_hit();
      @(posedge mclk);
      if (i == 0) soft_reset <= 1'b1;
      else if (i == 1) hard_reset <= 1'b1;
      else rst <= 1'b1;
      @(posedge mclk);
      soft_reset <= 1'b0;
      hard_reset <= 1'b0;
      rst <= 1'b0;
      #1;
      check(error_n_oe === 1'b1 && err_status === '0, "reset clear");
    end
    $display("test resets done");
  endtask
  task automatic test_inband;
    ecc_hit();
    p = pulses;
    for (int i = 0; i < pulse_count; i++) begin
      u_host_model.frame(reset_pattern[pulse_count - 1 - i], 1'b0);
    end
    #1;
    check(pulses == p + 1, "no in-band reset");
    check(error_n_oe === 1'b1 && err_status === '0, "in-band clear");
    check(oe_low == 0, "data line driven before clock");
    check(device_busy === 1'b1, "busy window missing");
    ecc_hit();
    op(error_clear_opcode);
    check(error_n_oe === 1'b0, "clear taken while busy");
    for (int k = 0; k < 4 * reset_busy_cycles && device_busy === 1'b1; k++) @(posedge mclk);
    #1;
    check(device_busy === 1'b0, "busy window never ended");
    op(error_clear_opcode);
    check(error_n_oe === 1'b1 && err_status === '0, "clear after busy");
    $display("test inband done");
  endtask
  task automatic test_bad;
    logic [3:0] bad;
    bad = 4'b0110;
    p = pulses;
    for (int i = 0; i < pulse_count; i++) u_host_model.frame(bad[i], 1'b0);
    for (int i = 0; i < pulse_count - 1; i++) begin
      u_host_model.frame(reset_pattern[pulse_count - 1 - i], 1'b0);
    end
    q = oe_low;
    u_host_model.frame(reset_pattern[0], 1'b1);
    #1;
    check(pulses == p, "reset from broken sequence");
    check(oe_low > q, "data line never driven after clock");
    @(posedge mclk);
    dq0_out_req <= 1'b0;
    q = oe_low;
    u_host_model.frame(reset_pattern[0], 1'b1);
    #1;
    check(oe_low == q, "data line driven without request");
    $display("test bad pattern done");
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    test_clear();
    test_resets();
    test_inband();
    test_clear();
    test_bad();
    report_and_stop();
  end
endmodule
